/* File: inc/pdt_consts.svh */
`ifndef PDT_CONSTS_SVH
`define PDT_CONSTS_SVH
`define PDT_ADDR_W 4
`define PDT_REG_CTRL 4'h0
`define PDT_REG_SLOT 4'h1
`define PDT_REG_COL 4'h2
`define PDT_REG_ROW 4'h3
`define PDT_REG_ENTRY_ON 4'h4
`define PDT_REG_TT_INDEX 4'h5
`define PDT_REG_TT_WDATA 4'h6
`define PDT_REG_TT_ENTRY 4'h7
`define PDT_CTRL_FIX_BIT 0
`define PDT_CTRL_TT_EN_BIT 1
`define PDT_CTRL_SRC_BIT 2
`define PDT_CTRL_BUSY_BIT 3
`define PDT_LIST_DEPTH 512
`define PDT_TT_DEPTH 4096
`define PDT_PIX_W 12
`define PDT_COORD_W 12
`define PDT_SENSOR_COLS 12'h990
`define PDT_SENSOR_ROWS 12'h800
`define PDT_PHASE_STEP 1
`endif

/* File: inc/pdt_pkg.sv */
package pdt_pkg;
  typedef logic [11:0] pdt_pix_t;
  typedef logic [11:0] pdt_coord_t;
  typedef enum logic [0:0] {
    PDT_SRC_GAMMA = 1'b0,
    PDT_SRC_USER = 1'b1
  } pdt_src_e;
  typedef enum logic [0:0] {
    PDT_CHOICE_LUMA = 1'b0
  } pdt_choice_e;
endpackage

/* File: logic/pdt_defect_list.sv */
`timescale 1ns/1ps
`include "pdt_consts.svh"
module pdt_defect_list #(
  parameter int DEPTH = `PDT_LIST_DEPTH,
  parameter int AW = $clog2(`PDT_LIST_DEPTH)
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [AW-1:0] i_slot,
  input wire logic i_wr,
  input wire pdt_pkg::pdt_coord_t i_col,
  input wire pdt_pkg::pdt_coord_t i_row,
  input wire logic i_on,
  input wire logic i_snap,
  input wire pdt_pkg::pdt_coord_t i_cur_col,
  input wire pdt_pkg::pdt_coord_t i_cur_row,
  output logic o_hit
);
  import pdt_pkg::*;
  // ==========================================================
  // software copy and the copy used by the stream
  typedef struct packed {
    logic [DEPTH-1:0] sw_on;
    logic [DEPTH-1:0] live_on;
  } pdt_dl_s;
  pdt_dl_s st_q;
  pdt_dl_s st_d;
  pdt_coord_t sw_col [DEPTH];
  pdt_coord_t sw_row [DEPTH];
  pdt_coord_t live_col [DEPTH];
  pdt_coord_t live_row [DEPTH];
  logic [DEPTH-1:0] match;

  always_comb begin
    st_d = st_q;
    if (i_wr) begin
      st_d.sw_on[i_slot] = i_on;
    end
    if (i_snap) begin
      st_d.live_on = st_q.sw_on;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // arrays kept out of reset so they can map to memory-like storage
  always_ff @(posedge i_ref_clk) begin
    if (i_wr) begin
      sw_col[i_slot] <= i_col;
      sw_row[i_slot] <= i_row;
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge i_ref_clk) begin
        if (i_snap) begin
          live_col[g] <= sw_col[g];
          live_row[g] <= sw_row[g];
        end
      end
      assign match[g] = st_q.live_on[g] && live_col[g] == i_cur_col && live_row[g] == i_cur_row;
    end
  endgenerate

  assign o_hit = |match;
endmodule

/* File: logic/pdt_tone_table.sv */
`timescale 1ns/1ps
`include "pdt_consts.svh"
module pdt_tone_table #(
  parameter int DEPTH = `PDT_TT_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_wr,
  input wire pdt_pkg::pdt_pix_t i_waddr,
  input wire pdt_pkg::pdt_pix_t i_wdata,
  input wire pdt_pkg::pdt_pix_t i_raddr_a,
  output pdt_pkg::pdt_pix_t o_rdata_a,
  input wire pdt_pkg::pdt_pix_t i_raddr_b,
  output pdt_pkg::pdt_pix_t o_rdata_b
);
  import pdt_pkg::*;
  // ==========================================================
  // one shared table, so every colour channel sees the same curve
  pdt_pix_t mem [DEPTH];

  always_ff @(posedge i_ref_clk) begin
    if (i_wr) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata_a <= mem[i_raddr_a];
    o_rdata_b <= mem[i_raddr_b];
  end
endmodule

/* File: logic/pdt_pixel_fix.sv */
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "pdt_consts.svh"
module pdt_pixel_fix #(
  parameter int LIST_DEPTH = `PDT_LIST_DEPTH,
  parameter int PHASE_STEP = `PDT_PHASE_STEP,
  parameter logic [11:0] SENSOR_COLS = `PDT_SENSOR_COLS,
  parameter logic [11:0] SENSOR_ROWS = `PDT_SENSOR_ROWS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [`PDT_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_acq_start,
  input wire logic i_acq_stop,
  input wire logic i_gamma_wr,
  input wire pdt_pkg::pdt_pix_t i_gamma_index,
  input wire pdt_pkg::pdt_pix_t i_gamma_value,
  input wire logic i_pix_valid,
  input wire logic i_pix_sof,
  input wire logic i_pix_sol,
  input wire pdt_pkg::pdt_pix_t i_pix,
  output logic o_pix_valid,
  output logic o_pix_sof,
  output logic o_pix_sol,
  output pdt_pkg::pdt_pix_t o_pix
);
  import pdt_pkg::*;

  localparam int SAW = $clog2(LIST_DEPTH);
  localparam int DW = 2 * PHASE_STEP + 1;

  // ==========================================================
  // state
  typedef struct packed {
    logic fix_en;
    logic tt_en;
    pdt_src_e src;
    logic acq_on;
    logic [SAW-1:0] slot;
    pdt_coord_t col;
    pdt_coord_t row;
    logic on;
    pdt_pix_t tt_index;
    logic [31:0] rdata;
    pdt_coord_t cur_col;
    pdt_coord_t cur_row;
    logic [DW-1:0][11:0] win;
    logic [DW-1:0] win_v;
    logic [DW-1:0] win_sof;
    logic [DW-1:0] win_sol;
    logic [DW-1:0] win_bad;
    logic fx_v;
    logic fx_sof;
    logic fx_sol;
    pdt_pix_t fx_pix;
    logic out_v;
    logic out_sof;
    logic out_sol;
    logic out_tt;
    pdt_pix_t out_raw;
  } pdt_s;
  pdt_s st_q;
  pdt_s st_d;

  logic hit;
  logic snap;
  logic tt_wr;
  pdt_pix_t tt_waddr;
  pdt_pix_t tt_wdata;
  pdt_pix_t tt_pix;
  pdt_pix_t tt_rd;
  logic [12:0] avg_sum;
  pdt_pix_t left_pix;

  function automatic pdt_coord_t clamp_coord(input logic [31:0] v, input logic [11:0] lim);
    clamp_coord = (v > {20'h0, lim}) ? lim : v[11:0];
  endfunction

  function automatic logic sel(input logic [3:0] a, input logic [3:0] r);
    sel = (a == r);
  endfunction

  // ==========================================================
  // submodules
  assign snap = i_acq_start && !st_q.acq_on;

  pdt_defect_list #(
    .DEPTH(LIST_DEPTH),
    .AW(SAW)
  ) u_list (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_slot(st_q.slot),
    .i_wr(i_wr && sel(i_addr, `PDT_REG_ENTRY_ON)),
    .i_col(st_q.col),
    .i_row(st_q.row),
    .i_on(i_wdata[0]),
    .i_snap(snap),
    .i_cur_col(st_q.cur_col),
    .i_cur_row(st_q.cur_row),
    .o_hit(hit)
  );

  // gamma feed wins only while gamma is the chosen source
  always_comb begin
    tt_wr = 1'b0;
    tt_waddr = st_q.tt_index;
    tt_wdata = i_wdata[11:0];
    if (st_q.src == PDT_SRC_GAMMA) begin
      tt_wr = i_gamma_wr;
      tt_waddr = i_gamma_index;
      tt_wdata = i_gamma_value;
    end else if (i_wr && sel(i_addr, `PDT_REG_TT_WDATA)) begin
      tt_wr = 1'b1;
    end
  end

  pdt_tone_table #(
    .DEPTH(`PDT_TT_DEPTH)
  ) u_tt (
    .i_ref_clk(i_ref_clk),
    .i_wr(tt_wr),
    .i_waddr(tt_waddr),
    .i_wdata(tt_wdata),
    .i_raddr_a(st_q.fx_pix),
    .o_rdata_a(tt_pix),
    .i_raddr_b(st_q.tt_index),
    .o_rdata_b(tt_rd)
  );

  // ==========================================================
  // correction datapath
  // left neighbour is the already corrected output of the fixer
  assign left_pix = st_q.fx_pix;
  // right neighbour is the newest raw pixel in the window
  assign avg_sum = {1'b0, left_pix} + {1'b0, st_q.win[DW-1]};

  always_comb begin
    st_d = st_q;
    if (i_acq_start) begin
      st_d.acq_on = 1'b1;
    end
    if (i_acq_stop) begin
      st_d.acq_on = 1'b0;
    end
    if (i_wr) begin
      case (i_addr)
        `PDT_REG_CTRL: begin
          st_d.fix_en = i_wdata[`PDT_CTRL_FIX_BIT];
          st_d.tt_en = i_wdata[`PDT_CTRL_TT_EN_BIT];
          st_d.src = pdt_src_e'(i_wdata[`PDT_CTRL_SRC_BIT]);
        end
        `PDT_REG_SLOT: st_d.slot = i_wdata[SAW-1:0];
        `PDT_REG_COL: st_d.col = clamp_coord(i_wdata, SENSOR_COLS);
        `PDT_REG_ROW: st_d.row = clamp_coord(i_wdata, SENSOR_ROWS);
        `PDT_REG_ENTRY_ON: st_d.on = i_wdata[0];
        `PDT_REG_TT_INDEX: st_d.tt_index = i_wdata[11:0];
        default: begin
        end
      endcase
    end
    st_d.rdata = '0;
    // read data registered at the strobe edge, so it stands in the next cycle
    if (i_rd) begin
      case (i_addr)
        `PDT_REG_CTRL: st_d.rdata = {28'h0, st_q.acq_on, st_q.src, st_q.tt_en, st_q.fix_en};
        `PDT_REG_SLOT: st_d.rdata = 32'(st_q.slot);
        `PDT_REG_COL: st_d.rdata = {20'h0, st_q.col};
        `PDT_REG_ROW: st_d.rdata = {20'h0, st_q.row};
        `PDT_REG_ENTRY_ON: st_d.rdata = {31'h0, st_q.on};
        `PDT_REG_TT_INDEX: st_d.rdata = {20'h0, st_q.tt_index};
        `PDT_REG_TT_ENTRY: st_d.rdata = {20'h0, tt_rd};
        default: st_d.rdata = '0;
      endcase
    end
    // position counters follow the input stream
    if (i_pix_valid) begin
      if (i_pix_sof) begin
        st_d.cur_col = '0;
        st_d.cur_row = '0;
      end else if (i_pix_sol) begin
        st_d.cur_col = '0;
        st_d.cur_row = st_q.cur_row + 12'h001;
      end else begin
        st_d.cur_col = st_q.cur_col + 12'h001;
      end
    end
    // window slides every cycle with its valid bits, so the last pixel still drains
    st_d.win = {i_pix, st_q.win[DW-1:1]};
    st_d.win_sof = {i_pix_sof, st_q.win_sof[DW-1:1]};
    st_d.win_sol = {i_pix_sol, st_q.win_sol[DW-1:1]};
    st_d.win_bad = {1'b0, st_q.win_bad[DW-1:1]};
    st_d.win_v = {i_pix_valid, st_q.win_v[DW-1:1]};
    st_d.fx_v = st_q.win_v[PHASE_STEP];
    if (st_q.win_v[DW-1] && hit && st_q.fix_en) begin
      st_d.win_bad[DW-2] = 1'b1;
    end
    if (st_q.win_v[PHASE_STEP]) begin
      st_d.fx_sof = st_q.win_sof[PHASE_STEP];
      st_d.fx_sol = st_q.win_sol[PHASE_STEP];
      st_d.fx_pix = st_q.win[PHASE_STEP];
      if (st_q.fix_en && st_q.win_bad[PHASE_STEP]) begin
        st_d.fx_pix = avg_sum[12:1];
      end
    end
    st_d.out_v = st_q.fx_v;
    st_d.out_sof = st_q.fx_sof;
    st_d.out_sol = st_q.fx_sol;
    st_d.out_tt = st_q.tt_en;
    st_d.out_raw = st_q.fx_pix;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs: table path and bypass share the same latency
  assign o_pix_valid = st_q.out_v;
  assign o_pix_sof = st_q.out_sof;
  assign o_pix_sol = st_q.out_sol;
  assign o_pix = st_q.out_tt ? tt_pix : st_q.out_raw;
  assign o_rdata = st_q.rdata;

  // ==========================================================
  // checks
  fix_off_pass_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (st_q.win_v[PHASE_STEP] && !st_q.fix_en) |=> st_q.fx_pix == $past(st_q.win[PHASE_STEP]))
    else $error("pixel changed with correction off");
  col_clamp_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    st_q.col <= SENSOR_COLS && st_q.row <= SENSOR_ROWS)
    else $error("coordinate beyond sensor");
  no_hit_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (st_q.win_v[DW-1] && !hit) |=> !st_q.win_bad[DW-2])
    else $error("pixel flagged without a hit");
  fix_avg_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (st_q.win_v[PHASE_STEP] && st_q.fix_en && st_q.win_bad[PHASE_STEP])
      |=> st_q.fx_pix == $past(avg_sum[12:1]))
    else $error("bad pixel not averaged");
  tt_bypass_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (st_q.fx_v && !st_q.tt_en) |=> o_pix_valid && o_pix == $past(st_q.fx_pix))
    else $error("bypass altered pixel");
  tt_latency_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    st_q.win_v[PHASE_STEP] |-> ##2 o_pix_valid)
    else $error("output latency wrong");
  idx_store_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_wr && i_addr == `PDT_REG_TT_INDEX) |=> st_q.tt_index == $past(i_wdata[11:0]))
    else $error("table index not stored");
  entry_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_rd && i_addr == `PDT_REG_TT_ENTRY) |=> o_rdata[31:12] == 20'h0)
    else $error("entry read too wide");
  fix_en_wr_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_wr && i_addr == `PDT_REG_CTRL) |=> st_q.fix_en == $past(i_wdata[0]))
    else $error("fix enable not stored");
endmodule

/* File: test/pdt_sensor_model.sv */
`timescale 1ns/1ps
module pdt_sensor_model #(
  parameter int COLS = 16,
  parameter int ROWS = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_go,
  output logic o_valid,
  output logic o_sof,
  output logic o_sol,
  output pdt_pkg::pdt_pix_t o_pix
);
  import pdt_pkg::*;
  int seed = 85;
  pdt_pix_t raw [ROWS*COLS];
  initial begin
    o_valid = 1'b0;
    o_sof = 1'b0;
    o_sol = 1'b0;
    o_pix = 12'h000;
  end
  // =====================
  // full raw frame, unbroken valid so every pixel but the last has a right neighbour
  always @(posedge i_ref_clk) begin
    if (i_go) begin
      for (int n = 0; n < ROWS*COLS; n++) begin
        raw[n] = pdt_pix_t'($random(seed));
        o_valid <= 1'b1;
        o_sof <= (n == 0);
        o_sol <= (n % COLS == 0) && (n != 0);
        o_pix <= raw[n];
        @(posedge i_ref_clk);
      end
      o_valid <= 1'b0;
      o_sof <= 1'b0;
      o_sol <= 1'b0;
      // idle data must not look like the last pixel
      o_pix <= ~o_pix;
    end
  end
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`include "pdt_consts.svh"
module tb_top;
  import pdt_pkg::*;
  localparam int C = 16;
  localparam int R = 4;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic acq_start = 1'b0;
  logic acq_stop = 1'b0;
  logic gamma_wr = 1'b0;
  pdt_pix_t gamma_index = 12'h000;
  pdt_pix_t gamma_value = 12'h000;
  logic go = 1'b0;
  logic [31:0] rdata;
  logic iv, isof, isol, ov, osof, osol;
  pdt_pix_t ipix, opix;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int t_in = 0;
  int t_out = 0;
  logic [31:0] d;
  pdt_pix_t outq [$];
  bit solq [$];
  int ti;
  bit pend_bad [R*C];
  bit live_bad [R*C];
  always #2.5 clk = ~clk;
  pdt_sensor_model #(.COLS(C), .ROWS(R)) u_src (.i_ref_clk(clk), .i_go(go), .o_valid(iv), .o_sof(isof),
    .o_sol(isol), .o_pix(ipix));
  pdt_pixel_fix u_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_acq_start(acq_start), .i_acq_stop(acq_stop), .i_gamma_wr(gamma_wr),
    .i_gamma_index(gamma_index), .i_gamma_value(gamma_value), .i_pix_valid(iv), .i_pix_sof(isof),
    .i_pix_sol(isol), .i_pix(ipix), .o_pix_valid(ov), .o_pix_sof(osof), .o_pix_sol(osol), .o_pix(opix));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (iv === 1'b1 && isof === 1'b1) t_in <= cyc;
    if (ov === 1'b1 && osof === 1'b1) t_out <= cyc;
    if (ov === 1'b1) outq.push_back(opix);
    if (ov === 1'b1) solq.push_back(osol === 1'b1);
  end
  // =====================
  // checking
  task automatic chk(string what, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic chk_pix(string what, pdt_pix_t e, pdt_pix_t s);
    chk(what, 32'(e), 32'(s));
  endtask
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // =====================
  // register bus
  task automatic wreg(logic [3:0] a, logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic add(int slot, int col, int row, logic on);
    wreg(`PDT_REG_SLOT, slot);
    wreg(`PDT_REG_COL, col);
    wreg(`PDT_REG_ROW, row);
    wreg(`PDT_REG_ENTRY_ON, {31'h0, on});
    pend_bad[row*C+col] = on;
  endtask
  // restart copies the staged list into the live one
  task automatic restart();
    @(posedge clk);
    acq_stop <= 1'b1;
    @(posedge clk);
    acq_stop <= 1'b0;
    acq_start <= 1'b1;
    @(posedge clk);
    acq_start <= 1'b0;
    live_bad = pend_bad;
  endtask
  function automatic pdt_pix_t tt_f(int i);
    return pdt_pix_t'(i * 7 ^ 12'h5a3);
  endfunction
  task automatic run_frame(logic fix, logic tt);
    pdt_pix_t cor [R*C];
    outq.delete();
    solq.delete();
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (R*C+12) @(posedge clk);
    chk("pixel count", R*C, outq.size());
    chk("latency", 4, t_out - t_in);
    for (int n = 0; n < outq.size(); n++) begin
      cor[n] = u_src.raw[n];
      if (fix && live_bad[n]) cor[n] = pdt_pix_t'((13'(cor[n-1]) + 13'(u_src.raw[n+1])) >> 1);
      chk_pix("pixel", tt ? tt_f(cor[n]) : cor[n], outq[n]);
      chk("line start", 32'((n % C == 0) && (n != 0)), 32'(solq[n]));
    end
  endtask
  // =====================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rreg(`PDT_REG_CTRL, d);
    chk("ctrl reset", 32'h0, d);
    rreg(4'h9, d);
    chk("unmapped", 32'h0, d);
    @(posedge clk);
    gamma_wr <= 1'b1;
    gamma_index <= 12'h005;
    gamma_value <= 12'h123;
    @(posedge clk);
    gamma_wr <= 1'b0;
    wreg(`PDT_REG_TT_INDEX, 32'h5);
    wreg(`PDT_REG_TT_WDATA, 32'h777);
    rreg(`PDT_REG_TT_ENTRY, d);
    chk("gamma entry", 32'h123, d);
    wreg(`PDT_REG_CTRL, 32'h4);
    for (int i = 0; i < `PDT_TT_DEPTH; i++) begin
      wreg(`PDT_REG_TT_INDEX, i);
      wreg(`PDT_REG_TT_WDATA, tt_f(i));
    end
    for (int k = 0; k < 3; k++) begin
      ti = (k == 0) ? 0 : (k == 1) ? 1234 : 4095;
      wreg(`PDT_REG_TT_INDEX, ti);
      rreg(`PDT_REG_TT_INDEX, d);
      chk("tt index", ti, d);
      rreg(`PDT_REG_TT_ENTRY, d);
      chk("tt entry", 32'(tt_f(ti)), d);
    end
    wreg(`PDT_REG_COL, 32'hfff);
    rreg(`PDT_REG_COL, d);
    chk("col clamp", 32'(`PDT_SENSOR_COLS), d);
    wreg(`PDT_REG_ROW, 32'hfff);
    rreg(`PDT_REG_ROW, d);
    chk("row clamp", 32'(`PDT_SENSOR_ROWS), d);
    // free slots never get coordinates written, but reset leaves them off
    add(0, 5, 1, 1'b1);
    add(1, 6, 1, 1'b1);
    add(2, 9, 2, 1'b0);
    restart();
    run_frame(1'b0, 1'b0);
    wreg(`PDT_REG_CTRL, 32'h5);
    rreg(`PDT_REG_CTRL, d);
    chk("ctrl running", 32'hd, d);
    run_frame(1'b1, 1'b0);
    add(3, 3, 2, 1'b1);
    run_frame(1'b1, 1'b0);
    restart();
    wreg(`PDT_REG_CTRL, 32'h7);
    run_frame(1'b1, 1'b1);
    results();
  end
  initial begin
    #300000;
    errors++;
    results();
  end
endmodule
